// *** pst_host.sv ***
// Host model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module pst_host (
    input wire logic core_clk,
    input wire logic rdValid_q,
    input wire logic [15:0] rdData_q,
    output var pst_pkg::pst_req_t hostReq
);
    initial hostReq = '0;
    // A request stands for exactly one edge: the bank never stalls
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        @(posedge core_clk);
        #1 hostReq = '{wrEn: 1'b1, rdEn: 1'b0, cmd: cmd, wrData: d};
        @(posedge core_clk);
        #1 hostReq = '0;
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
        @(posedge core_clk);
        #1 hostReq = '{wrEn: 1'b0, rdEn: 1'b1, cmd: cmd, wrData: 16'h0000};
        @(posedge core_clk);
        #1 hostReq = '0;
        ok = rdValid_q;
        d = rdData_q;
    endtask
endmodule
`default_nettype wire

// *** pst_pkg.sv ***
// Package for the sequencing, status and telemetry register subset
package pst_pkg;
    // Command codes
    localparam logic [7:0] CMD_SS_TIMEOUT_LIMIT = 8'h62;
    localparam logic [7:0] CMD_SS_TIMEOUT_ACTION = 8'h63;
    localparam logic [7:0] CMD_TURN_OFF_DELAY = 8'h64;
    localparam logic [7:0] CMD_SOFT_STOP_FALL = 8'h65;
    localparam logic [7:0] CMD_CRIT_SUMMARY = 8'h78;
    localparam logic [7:0] CMD_FAULT_SUMMARY = 8'h79;
    localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7a;
    localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7b;
    localparam logic [7:0] CMD_INPUT_FLAGS = 8'h7c;
    localparam logic [7:0] CMD_TEMP_FLAGS = 8'h7d;
    localparam logic [7:0] CMD_COMM_FLAGS = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h80;
    localparam logic [7:0] CMD_MEAS_VOUT = 8'h8b;
    localparam logic [7:0] CMD_MEAS_IOUT = 8'h8c;
    localparam logic [7:0] CMD_MEAS_TEMP = 8'h8e;
    localparam logic [7:0] CMD_PROTO_REV = 8'h98;
    localparam logic [7:0] CMD_VOUT_FLOOR = 8'ha4;
    // Reset values
    localparam logic [15:0] RST_SS_TIMEOUT_LIMIT = 16'h0064;
    localparam logic [7:0] RST_SS_TIMEOUT_ACTION = 8'hbf;
    localparam logic [15:0] RST_TURN_OFF_DELAY = 16'h0000;
    localparam logic [15:0] RST_SOFT_STOP_FALL = 16'h0000;
    localparam logic [15:0] RST_VOUT_FLOOR = 16'h0100;
    localparam logic [15:0] FIXED_TEMP_25C = 16'h0019;
    localparam logic [7:0] PROTO_REV_VALUE = 8'h12;
    // Linear voltage format exponent, two's complement five bits
    localparam logic [4:0] VOUT_EXPONENT = 5'h17;
    // Timing: one millisecond in core_clk cycles at 200 MHz
    localparam int CLK_MHZ = 200;
    localparam int MS_US = 1000;
    localparam int MS_CYCLES = CLK_MHZ * MS_US;
    localparam logic [17:0] MS_LAST = 18'(MS_CYCLES - 1);

    // Host register access request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] cmd;
        logic [15:0] wrData;
    } pst_req_t;

    // Live status inputs from the converter
    typedef struct packed {
        logic [7:0] critical;
        logic [15:0] summary;
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] input_;
        logic [7:0] temp;
        logic [7:0] comm;
        logic [7:0] vendor;
    } pst_status_t;

    // Stored copy of the non-volatile registers
    typedef struct packed {
        logic [7:0] ssAction;
        logic [15:0] offDelay;
        logic [15:0] fallTime;
    } pst_nvm_t;

    typedef enum logic [1:0] {
        SS_IDLE = 2'b00,
        SS_COUNT = 2'b01,
        SS_FAULT = 2'b10
    } pst_ss_state_t;
endpackage

// *** pst_regs.sv ***
// Register bank for soft-start timeout, turn-off timing, status and telemetry
`timescale 1ns/10ps
`default_nettype none
module pst_regs (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire pst_pkg::pst_req_t hostReq,
    input wire logic storeAll,
    input wire logic nvmValid,
    input wire pst_pkg::pst_nvm_t nvmLoad,
    input wire pst_pkg::pst_status_t statusIn,
    input wire logic [15:0] vinMeasVout,
    input wire logic [15:0] vinMeasIout,
    input wire logic [15:0] vinMeasTemp,
    input wire logic softstart_detect_disable,
    input wire logic softStartActive,
    input wire logic [15:0] requestedSetpoint,
    output logic [15:0] rdData_q,
    output logic rdValid_q,
    output logic [15:0] clampedSetpoint_q,
    output logic ssTimeoutFault_q,
    output logic [7:0] ssTimeoutAction_q,
    output logic [15:0] turnOffDelay_q,
    output logic [15:0] softStopFall_q,
    output logic nvmWrite_q,
    output pst_pkg::pst_nvm_t nvmStore_q
);
    logic [15:0] ssLimit_q;
    logic [15:0] floor_q;
    logic nvmLoaded_q;
    pst_pkg::pst_ss_state_t ssState_q;
    pst_pkg::pst_ss_state_t ssState_d;
    logic [17:0] subMs_q;
    logic [15:0] msCount_q;
    logic msTick;
    logic limitReached;
    logic nvmLoadNow;
    logic [15:0] rdMux;

    function automatic logic isWrite(input pst_pkg::pst_req_t r, input logic [7:0] c);
        isWrite = r.wrEn && (r.cmd == c);
    endfunction

    // Timeout limit is volatile: every reset brings back the default
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ssLimit_q <= pst_pkg::RST_SS_TIMEOUT_LIMIT;
        end else if (isWrite(hostReq, pst_pkg::CMD_SS_TIMEOUT_LIMIT)) begin
            ssLimit_q <= hostReq.wrData;
        end
    end

    // Floor is volatile too and shares the fixed voltage exponent
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            floor_q <= pst_pkg::RST_VOUT_FLOOR;
        end else if (isWrite(hostReq, pst_pkg::CMD_VOUT_FLOOR)) begin
            floor_q <= hostReq.wrData;
        end
    end

    // The stored image is taken once per reset; a write in that same cycle is lost
    assign nvmLoadNow = !nvmLoaded_q && nvmValid;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nvmLoaded_q <= 1'b0;
        end else if (nvmLoadNow) begin
            nvmLoaded_q <= 1'b1;
        end
    end

    // Load is a clocked capture after release, never an async reset value
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ssTimeoutAction_q <= pst_pkg::RST_SS_TIMEOUT_ACTION;
        end else if (nvmLoadNow) begin
            ssTimeoutAction_q <= nvmLoad.ssAction;
        end else if (isWrite(hostReq, pst_pkg::CMD_SS_TIMEOUT_ACTION)) begin
            // One-byte register: the upper write byte has nowhere to go
            ssTimeoutAction_q <= hostReq.wrData[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            turnOffDelay_q <= pst_pkg::RST_TURN_OFF_DELAY;
        end else if (nvmLoadNow) begin
            turnOffDelay_q <= nvmLoad.offDelay;
        end else if (isWrite(hostReq, pst_pkg::CMD_TURN_OFF_DELAY)) begin
            turnOffDelay_q <= hostReq.wrData;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            softStopFall_q <= pst_pkg::RST_SOFT_STOP_FALL;
        end else if (nvmLoadNow) begin
            softStopFall_q <= nvmLoad.fallTime;
        end else if (isWrite(hostReq, pst_pkg::CMD_SOFT_STOP_FALL)) begin
            softStopFall_q <= hostReq.wrData;
        end
    end

    // Store-all strobe toward the EEPROM, one cycle after the command
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nvmWrite_q <= 1'b0;
        end else begin
            nvmWrite_q <= storeAll;
        end
    end

    // Snapshot holds until the next store, so a slow EEPROM side may take it late
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nvmStore_q <= '0;
        end else if (storeAll) begin
            nvmStore_q <= {ssTimeoutAction_q, turnOffDelay_q, softStopFall_q};
        end
    end

    // Soft-start timeout: millisecond prescaler and counter restart on soft-start entry
    assign msTick = (subMs_q == pst_pkg::MS_LAST);
    // A limit of zero behaves like one millisecond
    assign limitReached = (msCount_q + 16'h0001 >= ssLimit_q);

    always_comb begin
        ssState_d = ssState_q;
        case (ssState_q)
            pst_pkg::SS_IDLE: begin
                if (softStartActive) begin
                    ssState_d = pst_pkg::SS_COUNT;
                end
            end
            pst_pkg::SS_COUNT: begin
                if (!softStartActive) begin
                    ssState_d = pst_pkg::SS_IDLE;
                end else if (msTick && limitReached) begin
                    ssState_d = pst_pkg::SS_FAULT;
                end
            end
            pst_pkg::SS_FAULT: begin
                if (!softStartActive) begin
                    ssState_d = pst_pkg::SS_IDLE;
                end
            end
            default: ssState_d = pst_pkg::SS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ssState_q <= pst_pkg::SS_IDLE;
        end else begin
            ssState_q <= ssState_d;
        end
    end

    // Prescaler and count restart whenever soft-start is not being timed
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            subMs_q <= '0;
        end else if (ssState_q != pst_pkg::SS_COUNT) begin
            subMs_q <= '0;
        end else if (msTick) begin
            subMs_q <= '0;
        end else begin
            subMs_q <= subMs_q + 18'h00001;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msCount_q <= '0;
        end else if (ssState_q != pst_pkg::SS_COUNT) begin
            msCount_q <= '0;
        end else if (msTick) begin
            msCount_q <= msCount_q + 16'h0001;
        end
    end

    // Flag follows the next state so it rises on the same edge as the fault state
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ssTimeoutFault_q <= 1'b0;
        end else begin
            ssTimeoutFault_q <= (ssState_d == pst_pkg::SS_FAULT);
        end
    end

    // Setpoint floor, both values share the fixed exponent so compare mantissas
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clampedSetpoint_q <= pst_pkg::RST_VOUT_FLOOR;
        end else if (requestedSetpoint < floor_q) begin
            clampedSetpoint_q <= floor_q;
        end else begin
            clampedSetpoint_q <= requestedSetpoint;
        end
    end

    // Read decode; writes to read-only codes simply match no write above
    always_comb begin
        if (hostReq.cmd == pst_pkg::CMD_SS_TIMEOUT_LIMIT) begin
            rdMux = ssLimit_q;
        end else if (hostReq.cmd == pst_pkg::CMD_SS_TIMEOUT_ACTION) begin
            rdMux = {8'h00, ssTimeoutAction_q};
        end else if (hostReq.cmd == pst_pkg::CMD_TURN_OFF_DELAY) begin
            rdMux = turnOffDelay_q;
        end else if (hostReq.cmd == pst_pkg::CMD_SOFT_STOP_FALL) begin
            rdMux = softStopFall_q;
        end else if (hostReq.cmd == pst_pkg::CMD_CRIT_SUMMARY) begin
            rdMux = {8'h00, statusIn.critical};
        end else if (hostReq.cmd == pst_pkg::CMD_FAULT_SUMMARY) begin
            rdMux = statusIn.summary;
        end else if (hostReq.cmd == pst_pkg::CMD_VOUT_FLAGS) begin
            rdMux = {8'h00, statusIn.vout};
        end else if (hostReq.cmd == pst_pkg::CMD_IOUT_FLAGS) begin
            rdMux = {8'h00, statusIn.iout};
        end else if (hostReq.cmd == pst_pkg::CMD_INPUT_FLAGS) begin
            rdMux = {8'h00, statusIn.input_};
        end else if (hostReq.cmd == pst_pkg::CMD_TEMP_FLAGS) begin
            rdMux = {8'h00, statusIn.temp};
        end else if (hostReq.cmd == pst_pkg::CMD_COMM_FLAGS) begin
            rdMux = {8'h00, statusIn.comm};
        end else if (hostReq.cmd == pst_pkg::CMD_VENDOR_FLAGS) begin
            rdMux = {8'h00, statusIn.vendor};
        end else if (hostReq.cmd == pst_pkg::CMD_MEAS_VOUT) begin
            rdMux = vinMeasVout;
        end else if (hostReq.cmd == pst_pkg::CMD_MEAS_IOUT) begin
            rdMux = vinMeasIout;
        end else if (hostReq.cmd == pst_pkg::CMD_MEAS_TEMP) begin
            // Detection enabled means the temperature sensor reading is not trusted
            rdMux = softstart_detect_disable ? vinMeasTemp : pst_pkg::FIXED_TEMP_25C;
        end else if (hostReq.cmd == pst_pkg::CMD_PROTO_REV) begin
            rdMux = {8'h00, pst_pkg::PROTO_REV_VALUE};
        end else if (hostReq.cmd == pst_pkg::CMD_VOUT_FLOOR) begin
            rdMux = floor_q;
        end else begin
            rdMux = 16'h0000;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= hostReq.rdEn;
        end
    end

    // Read data holds until the next read, so a slow host can still pick it up
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_q <= 16'h0000;
        end else if (hostReq.rdEn) begin
            rdData_q <= rdMux;
        end
    end
endmodule
`default_nettype wire

// *** pst_regs_sva.sv ***
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
`default_nettype none
module pst_regs_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire pst_pkg::pst_req_t hostReq,
    input wire logic storeAll,
    input wire logic softstart_detect_disable,
    input wire logic softStartActive,
    input wire logic [15:0] requestedSetpoint,
    input wire logic [15:0] rdData_q,
    input wire logic [15:0] clampedSetpoint_q,
    input wire logic ssTimeoutFault_q,
    input wire logic [7:0] ssTimeoutAction_q,
    input wire logic [15:0] turnOffDelay_q,
    input wire logic [15:0] softStopFall_q,
    input wire logic nvmWrite_q,
    input wire pst_pkg::pst_nvm_t nvmStore_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] floor_q;
    // Shadow of the floor so the clamp can be judged without peeking inside
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            floor_q <= pst_pkg::RST_VOUT_FLOOR;
        else if (hostReq.wrEn && hostReq.cmd == pst_pkg::CMD_VOUT_FLOOR)
            floor_q <= hostReq.wrData;
    end
    a_revision_read: assert property (
        hostReq.rdEn && hostReq.cmd == pst_pkg::CMD_PROTO_REV |=> rdData_q == 16'h0012)
        else $error("revision read wrong");
    a_fixed_temp: assert property (
        hostReq.rdEn && hostReq.cmd == pst_pkg::CMD_MEAS_TEMP && !softstart_detect_disable
        |=> rdData_q == 16'h0019) else $error("fixed temperature read wrong");
    a_setpoint_clamp: assert property (
        !$past(sys_rst) |-> clampedSetpoint_q == (($past(requestedSetpoint) < $past(floor_q))
        ? $past(floor_q) : $past(requestedSetpoint))) else $error("setpoint clamp wrong");
    a_fault_clears: assert property (
        !softStartActive |=> !ssTimeoutFault_q) else $error("timeout flag stays up");
    a_no_early_fault: assert property (
        $rose(softStartActive) |=> !ssTimeoutFault_q [*8]) else $error("timeout too early");
    a_store_image: assert property (
        storeAll |=> nvmWrite_q && nvmStore_q ==
        $past({ssTimeoutAction_q, turnOffDelay_q, softStopFall_q})) else $error("store wrong");
    a_action_write: assert property (
        hostReq.wrEn && hostReq.cmd == pst_pkg::CMD_SS_TIMEOUT_ACTION
        |=> ssTimeoutAction_q == $past(hostReq.wrData[7:0])) else $error("action not written");
    a_delay_write: assert property (
        hostReq.wrEn && hostReq.cmd == pst_pkg::CMD_TURN_OFF_DELAY
        |=> turnOffDelay_q == $past(hostReq.wrData)) else $error("delay not written");
endmodule
bind pst_regs pst_regs_chk chk_u (.core_clk, .sys_rst, .hostReq, .storeAll,
    .softstart_detect_disable, .softStartActive, .requestedSetpoint, .rdData_q,
    .clampedSetpoint_q, .ssTimeoutFault_q, .ssTimeoutAction_q, .turnOffDelay_q,
    .softStopFall_q, .nvmWrite_q, .nvmStore_q);
`default_nettype wire

// *** pst_regs_tb.sv ***
// Self-checking bench for the sequencing, status and telemetry register bank
`timescale 1ns/10ps
`default_nettype none
module pmbus_seq_status_telemetry_regs_tb_top;
    logic core_clk = 1'b0, sys_rst = 1'b1, storeAll = 1'b0, nvmValid = 1'b0;
    logic ssDis = 1'b0, ssAct = 1'b0, rdValid_q, fault, nvmWrite_q, ok;
    logic [15:0] vOut = 16'h0123, iOut = 16'hf856, tMeas = 16'h002d, reqSp = 16'h0000;
    logic [15:0] got, rdData_q, clampedSetpoint_q, offDelay, fallTime;
    logic [7:0] ssAction;
    pst_pkg::pst_nvm_t nvmLoad = '0, nvmStore_q;
    pst_pkg::pst_status_t statusIn = '0;
    pst_pkg::pst_req_t hostReq;
    int errors = 0, n_tests = 0, cyc = 0;
    logic [7:0] wCmd [8] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'ha4, 8'h98, 8'h78, 8'h8e};
    logic [15:0] wVal [8] = '{16'h0001, 16'h12a5, 16'hbeef, 16'h0a0b, 16'h0200,
        16'hffff, 16'hffff, 16'hffff};
    logic [15:0] wExp [8] = '{16'h0001, 16'h00a5, 16'hbeef, 16'h0a0b, 16'h0200,
        16'h0012, 16'h0000, 16'h0019};
    logic [7:0] sCmd [10] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80,
        8'h8b, 8'h8c};
    logic [15:0] sExp [10] = '{16'h0081, 16'h4282, 16'h0083, 16'h0084, 16'h0085,
        16'h0086, 16'h0087, 16'h0088, 16'h0123, 16'hf856};
    always #2.5 core_clk = ~core_clk;
    pst_regs dut_u (.core_clk, .sys_rst, .hostReq, .storeAll, .nvmValid, .nvmLoad, .statusIn,
        .vinMeasVout(vOut), .vinMeasIout(iOut), .vinMeasTemp(tMeas),
        .softstart_detect_disable(ssDis), .softStartActive(ssAct), .requestedSetpoint(reqSp),
        .rdData_q, .rdValid_q, .clampedSetpoint_q, .ssTimeoutFault_q(fault),
        .ssTimeoutAction_q(ssAction), .turnOffDelay_q(offDelay), .softStopFall_q(fallTime),
        .nvmWrite_q, .nvmStore_q);
    pst_host host_u (.core_clk, .rdValid_q, .rdData_q, .hostReq);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // A read without its valid pulse counts as unknown data
    task automatic rc(input logic [7:0] cmd, input logic [15:0] exp);
        host_u.rd(cmd, got, ok);
        chk($sformatf("reg %h", cmd), exp, (ok === 1'b1) ? got : 16'hxxxx);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        rc(pst_pkg::CMD_SS_TIMEOUT_LIMIT, 16'h0064);
        rc(pst_pkg::CMD_SS_TIMEOUT_ACTION, 16'h00bf);
        rc(pst_pkg::CMD_TURN_OFF_DELAY, 16'h0000);
        rc(pst_pkg::CMD_SOFT_STOP_FALL, 16'h0000);
        rc(pst_pkg::CMD_VOUT_FLOOR, 16'h0100);
        rc(pst_pkg::CMD_PROTO_REV, 16'h0012);
        $display("test reset values done");
        foreach (wCmd[i]) host_u.wr(wCmd[i], wVal[i]);
        chk("no valid on write", 16'h0000, {15'h0000, rdValid_q});
        foreach (wCmd[i]) rc(wCmd[i], wExp[i]);
        rc(8'h70, 16'h0000);
        chk("action port", 16'h00a5, {8'h00, ssAction});
        chk("fall port", 16'h0a0b, fallTime);
        chk("delay port", 16'hbeef, offDelay);
        $display("test write and readback done");
        statusIn = '{8'h81, 16'h4282, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88};
        foreach (sCmd[i]) rc(sCmd[i], sExp[i]);
        ssDis = 1'b1;
        rc(pst_pkg::CMD_MEAS_TEMP, 16'h002d);
        ssDis = 1'b0;
        $display("test status and telemetry done");
        reqSp = 16'h0150;
        repeat (2) @(posedge core_clk);
        #1 chk("clamp below floor", 16'h0200, clampedSetpoint_q);
        reqSp = 16'h0345;
        repeat (2) @(posedge core_clk);
        #1 chk("clamp above floor", 16'h0345, clampedSetpoint_q);
        $display("test setpoint floor done");
        ssAct = 1'b1;
        repeat (40) @(posedge core_clk);
        #1 chk("timeout before 1 ms", 16'h0000, {15'h0000, fault});
        ssAct = 1'b0;
        $display("test soft-start done");
        @(posedge core_clk);
        #1 storeAll = 1'b1;
        @(posedge core_clk);
        #1 storeAll = 1'b0;
        chk("store strobe", 16'h0001, {15'h0000, nvmWrite_q});
        chk("store action", 16'h00a5, {8'h00, nvmStore_q.ssAction});
        chk("store delay", 16'hbeef, nvmStore_q.offDelay);
        chk("store fall", 16'h0a0b, nvmStore_q.fallTime);
        $display("test store-all done");
        nvmLoad = '{8'hc3, 16'h1234, 16'h5678};
        nvmValid = 1'b1;
        sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        rc(pst_pkg::CMD_SS_TIMEOUT_ACTION, 16'h00c3);
        rc(pst_pkg::CMD_TURN_OFF_DELAY, 16'h1234);
        rc(pst_pkg::CMD_SOFT_STOP_FALL, 16'h5678);
        rc(pst_pkg::CMD_SS_TIMEOUT_LIMIT, 16'h0064);
        rc(pst_pkg::CMD_VOUT_FLOOR, 16'h0100);
        $display("test stored defaults done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
